/* rtl/calib_regs_pkg.sv */
// constants for the calibration, interrupt-enable, lot code and test registers
package calib_regs_pkg;
    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [7:0] ADDR_CALIB_STATUS = 8'hdc;
    localparam logic [7:0] ADDR_INT_ENABLE   = 8'hdd;
    localparam logic [7:0] ADDR_LOT_LOW      = 8'he6;
    localparam logic [7:0] ADDR_LOT_HIGH     = 8'he7;
    localparam logic [7:0] ADDR_TEST_SETTING = 8'hf2;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int BIT_DONE_MIRROR   = 0;
    localparam int BIT_OFFSET_ADJ    = 2;
    localparam int BIT_ZERO_EN       = 2;
    localparam int BIT_CALIB_EN      = 3;
    localparam int BIT_LIGHT_EN      = 4;
    localparam int BIT_PROX_THR_EN   = 5;
    localparam int BIT_PROX_SAT_EN   = 6;
    localparam int BIT_LIGHT_SAT_EN  = 7;
    localparam int NUM_IRQ_SOURCES   = 6;
    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [7:0] RST_CALIB_STATUS = 8'h00;
    localparam logic [7:0] RST_INT_ENABLE   = 8'h00;
    localparam logic [7:0] RST_TEST_SETTING = 8'h44;
    // arbitrary neutral lot code, real parts differ per unit
    localparam logic [15:0] LOT_CODE_DEFAULT = 16'h0000;
    // reserved-bit masks: writable fields only
    localparam logic [7:0] MASK_INT_ENABLE  = 8'hfc;
endpackage : calib_regs_pkg

/* rtl/offset_adjust_flag.sv */
// sticky flag for the automatic proximity offset decrement
`timescale 1ns/1ns
module offset_adjust_flag
(
    input  wire logic clk_sys,
    input  wire logic nrst,
    input  wire logic autoOffsetDecrementEnable,
    input  wire logic offsetDecrementEvent,
    input  wire logic clearWrite,
    output logic      offsetAutoDecrementedFlag
);
    logic flag_r;
    logic flag_nxt;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb
    begin
        flag_nxt = flag_r;
        if (clearWrite || !autoOffsetDecrementEnable)
        begin
            flag_nxt = 1'b0;
        end
        // set wins over a write-one clear in the same cycle
        if (offsetDecrementEvent && autoOffsetDecrementEnable)
        begin
            flag_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            flag_r <= 1'b0;
        end
        else
        begin
            flag_r <= flag_nxt;
        end
    end

    assign offsetAutoDecrementedFlag = flag_r;
endmodule : offset_adjust_flag

/* rtl/calib_status_irq_enable_regs.sv */
// calibration status, interrupt enable, lot code and test setting registers
// ----------------------------------------
// Behaviour
// - an automatic offset decrement while auto adjust is on sets status bit 2.
// - status bit 2 clears on a host write of 1 to it unless a decrement sets it in the same cycle, or when auto adjust is turned off.
// - status bit 0 always reads as the calibration interrupt flag.
// - status bit 0 falls in the same cycle the calibration interrupt flag is cleared.
// - enable bit 7 gates the light saturation interrupt and resets to 0.
// - enable bits 6 and 5 gate prox saturation and prox threshold and reset to 0.
// - enable bit 4 gates the light and colour threshold interrupt and resets to 0.
// - enable bit 3 gates the calibration interrupt and resets to 0.
// - enable bit 2 gates the zero-detect interrupt and resets to 0.
// - two read-only bytes present the factory lot code.
// ----------------------------------------
`timescale 1ns/1ns
module calib_status_irq_enable_regs
#(
    parameter logic [15:0] LOT_CODE = calib_regs_pkg::LOT_CODE_DEFAULT
)
(
    input  wire logic       clk_sys,
    input  wire logic       nrst,
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWdata,
    input  wire logic       regWrite,
    input  wire logic       regRead,
    output logic      [7:0] regRdata,
    input  wire logic       autoOffsetDecrementEnable,
    input  wire logic       offsetDecrementEvent,
    input  wire logic       calibrationIrqFlag,
    input  wire logic       lightSaturationFlag,
    input  wire logic       proxSaturationFlag,
    input  wire logic       proxThresholdFlag,
    input  wire logic       lightColorFlag,
    input  wire logic       zeroDetectFlag,
    output logic      [7:0] interruptEnable,
    output logic      [7:0] testSetting,
    output logic            offsetAutoDecrementedFlag,
    output logic            irqOut
);
    import calib_regs_pkg::*;

    logic [7:0] intEnable_r;
    logic [7:0] intEnable_nxt;
    logic [7:0] test_r;
    logic [7:0] test_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic       statusClear;
    logic       irq_r;
    logic       irq_nxt;
    logic [NUM_IRQ_SOURCES-1:0] srcFlags;
    logic [NUM_IRQ_SOURCES-1:0] srcEnables;
    logic [7:0] statusByte;

    // one address compare, shared by every write and clear decode
    function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
        hit = (a == target);
    endfunction : hit

    // ----------------------------------------
    // offset_auto_decremented_flag flag
    // ----------------------------------------
    // write-one clear acts on bit 2 alone, the other status bits ignore writes
    assign statusClear = regWrite && hit(regAddr, ADDR_CALIB_STATUS)
                         && regWdata[BIT_OFFSET_ADJ];

    offset_adjust_flag u_offset_flag
    (
        .clk_sys                   (clk_sys),
        .nrst                      (nrst),
        .autoOffsetDecrementEnable (autoOffsetDecrementEnable),
        .offsetDecrementEvent      (offsetDecrementEvent),
        .clearWrite                (statusClear),
        .offsetAutoDecrementedFlag (offsetAutoDecrementedFlag)
    );

    // ----------------------------------------
    // interrupt enable register
    // ----------------------------------------
    always_comb
    begin
        intEnable_nxt = intEnable_r;
        if (regWrite && hit(regAddr, ADDR_INT_ENABLE))
        begin
            // reserved bits kept at zero even if the host misbehaves
            intEnable_nxt = regWdata & MASK_INT_ENABLE;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            intEnable_r <= RST_INT_ENABLE;
        end
        else
        begin
            intEnable_r <= intEnable_nxt;
        end
    end

    // ----------------------------------------
    // test setting register
    // ----------------------------------------
    always_comb
    begin
        test_nxt = test_r;
        // no check of the value: the host owns the working setting
        if (regWrite && hit(regAddr, ADDR_TEST_SETTING))
        begin
            test_nxt = regWdata;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            test_r <= RST_TEST_SETTING;
        end
        else
        begin
            test_r <= test_nxt;
        end
    end

    // ----------------------------------------
    // status byte
    // ----------------------------------------
    always_comb
    begin
        statusByte                  = RST_CALIB_STATUS;
        // mirror read live, so it drops with the source flag
        statusByte[BIT_DONE_MIRROR] = calibrationIrqFlag;
        statusByte[BIT_OFFSET_ADJ]  = offsetAutoDecrementedFlag;
    end

    // ----------------------------------------
    // read path
    // ----------------------------------------
    always_comb
    begin
        rdata_nxt = rdata_r;
        if (regRead)
        begin
            unique case (regAddr)
                ADDR_CALIB_STATUS: rdata_nxt = statusByte;
                ADDR_INT_ENABLE:   rdata_nxt = intEnable_r;
                ADDR_LOT_LOW:      rdata_nxt = LOT_CODE[7:0];
                ADDR_LOT_HIGH:     rdata_nxt = LOT_CODE[15:8];
                ADDR_TEST_SETTING: rdata_nxt = test_r;
                // unmapped addresses read as zero
                default:           rdata_nxt = 8'h00;
            endcase
        end
    end

    // ----------------------------------------
    // read data register
    // ----------------------------------------
    // held between reads, so the serial side may fetch it late
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            rdata_r <= 8'h00;
        end
        else
        begin
            rdata_r <= rdata_nxt;
        end
    end

    // ----------------------------------------
    // interrupt combine
    // ----------------------------------------
    // source i sits under enable bit BIT_ZERO_EN + i
    assign srcFlags = {lightSaturationFlag, proxSaturationFlag, proxThresholdFlag,
                       lightColorFlag, calibrationIrqFlag, zeroDetectFlag};

    for (genvar i = 0; i < NUM_IRQ_SOURCES; i++)
    begin : g_gate
        assign srcEnables[i] = intEnable_r[BIT_ZERO_EN + i];
    end

    // the gating above needs the enable bits as one contiguous run
    if (BIT_ZERO_EN + NUM_IRQ_SOURCES - 1 != BIT_LIGHT_SAT_EN)
    begin : g_bad_map
        $error("interrupt enable map does not match the source count");
    end

    always_comb
    begin
        irq_nxt = |(srcFlags & srcEnables);
    end

    // registered so a glitching source cannot pulse the pin
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            irq_r <= 1'b0;
        end
        else
        begin
            irq_r <= irq_nxt;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign regRdata        = rdata_r;
    assign irqOut          = irq_r;
    assign interruptEnable = intEnable_r;
    assign testSetting     = test_r;
endmodule : calib_status_irq_enable_regs

/* test/calib_regs_checker.sv */
// assertion checker for the calibration register group
`timescale 1ns/1ns
module calib_regs_checker
(
    input wire logic       clk_sys,
    input wire logic       nrst,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic       regWrite,
    input wire logic       regRead,
    input wire logic [7:0] regRdata,
    input wire logic       autoOffsetDecrementEnable,
    input wire logic       offsetDecrementEvent,
    input wire logic       calibrationIrqFlag,
    input wire logic       lightSaturationFlag,
    input wire logic       proxSaturationFlag,
    input wire logic       proxThresholdFlag,
    input wire logic       lightColorFlag,
    input wire logic       zeroDetectFlag,
    input wire logic [7:0] interruptEnable,
    input wire logic       offsetAutoDecrementedFlag,
    input wire logic       irqOut
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    wire logic adj = autoOffsetDecrementEnable;
    wire logic fl = offsetAutoDecrementedFlag;
    wire logic wrSt = regWrite && regAddr == 8'hdc;
    wire logic wrEn = regWrite && regAddr == 8'hdd;
    // calibration flag is a live source, gated like the others
    wire logic cause = |({lightSaturationFlag, proxSaturationFlag, proxThresholdFlag,
        lightColorFlag, calibrationIrqFlag, zeroDetectFlag} & interruptEnable[7:2]);
    a_flag_set: assert property (
        adj && offsetDecrementEvent |=> fl) else $error("offset flag not set");
    a_flag_off: assert property (
        !adj |=> !fl) else $error("offset flag kept with auto adjust off");
    a_flag_wclr: assert property (
        wrSt && regWdata[2] && !offsetDecrementEvent |=> !fl) else $error("flag not cleared");
    a_status_read: assert property (
        regRead && regAddr == 8'hdc |=> regRdata == {5'h00, $past(fl), 1'b0,
        $past(calibrationIrqFlag)}) else $error("status read wrong");
    a_enable_write: assert property (
        wrEn |=> interruptEnable == ($past(regWdata) & 8'hfc)) else $error("enable write");
    a_enable_hold: assert property (
        !wrEn |=> $stable(interruptEnable)) else $error("enable changed without write");
    a_enable_rsvd: assert property (
        interruptEnable[1:0] == 2'b00) else $error("reserved enable bits set");
    a_irq_out: assert property (
        1'b1 |=> irqOut == $past(cause)) else $error("irq output wrong");
endmodule : calib_regs_checker
bind calib_status_irq_enable_regs calib_regs_checker chk_u (.*);

/* test/host_model.sv */
// host side of the register access port
`timescale 1ns/1ns
module host_model
(
    input  wire logic       clk_sys,
    output logic      [7:0] regAddr,
    output logic      [7:0] regWdata,
    output logic            regWrite,
    output logic            regRead
);
    initial {regAddr, regWdata, regWrite, regRead} = 18'h00000;
    // released lines flip, so a stale address never passes for a live one
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        {regAddr, regWdata, regWrite, regRead} <= {a, d, w, !w};
        @(posedge clk_sys);
        {regAddr, regWdata, regWrite, regRead} <= {~a, ~d, 2'b00};
    endtask : xfer
    task automatic enWr(input logic [7:0] d);
        xfer(1'b1, 8'hdd, d & 8'hfc);
    endtask : enWr
    task automatic stClr();
        xfer(1'b1, 8'hdc, 8'h04);
    endtask : stClr
endmodule : host_model

/* test/calib_status_irq_enable_regs_tb.sv */
// self-checking bench for the calibration register group
`timescale 1ns/1ns
module calib_status_irq_enable_regs_tb;
    import calib_regs_pkg::*;
    logic clk_sys = 1'b0, nrst = 1'b0, rdPend = 1'b0, regWrite, regRead, irqOut;
    logic autoOffsetDecrementEnable = 1'b0, offsetDecrementEvent = 1'b0;
    logic calibrationIrqFlag = 1'b0, lightSaturationFlag = 1'b0, proxSaturationFlag = 1'b0;
    logic proxThresholdFlag = 1'b0, lightColorFlag = 1'b0, zeroDetectFlag = 1'b0;
    logic offsetAutoDecrementedFlag;
    logic [7:0]  regAddr, regWdata, regRdata, interruptEnable, testSetting;
    logic [31:0] seed = 32'hc5bb70ff;
    logic [7:0]  expQ[$];
    logic [9:0]  outQ[$];
    logic [9:0]  outNote;
    int          fail_count = 0, total_checks = 0;
    always #5 clk_sys = ~clk_sys;
    host_model host_u (.*);
    calib_status_irq_enable_regs dut_u (.*);
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check8
    task automatic checkBit(input logic got, input logic exp);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : checkBit
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        expQ.push_back(e);
        host_u.xfer(1'b0, a, 8'h00);
    endtask : rd
    task automatic pulse();
        @(posedge clk_sys);
        offsetDecrementEvent <= 1'b1;
        @(posedge clk_sys);
        offsetDecrementEvent <= 1'b0;
    endtask : pulse
    always @(posedge clk_sys) rdPend <= regRead;
    always @(negedge clk_sys)
        if (rdPend && expQ.size() > 0)
            check8(regRdata, expQ.pop_front());
    // notes hold {flag, irq, enable}, pushed once the outputs have settled
    always @(negedge clk_sys)
        if (outQ.size() > 0)
        begin
            outNote = outQ.pop_front();
            check8(interruptEnable, outNote[7:0]);
            checkBit(irqOut, outNote[8]);
            checkBit(offsetAutoDecrementedFlag, outNote[9]);
        end
    task automatic test_done();
        $display("checks=%0d mismatches=%0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : test_done
    initial
    begin
        #100000;
        fail_count++;
        test_done();
    end
    initial
    begin
        repeat (16) @(posedge clk_sys);
        nrst <= 1'b1;
        check8(testSetting, RST_TEST_SETTING);
        rd(ADDR_CALIB_STATUS, RST_CALIB_STATUS);
        rd(ADDR_INT_ENABLE, RST_INT_ENABLE);
        rd(ADDR_TEST_SETTING, RST_TEST_SETTING);
        host_u.xfer(1'b1, ADDR_LOT_LOW, 8'ha5);
        rd(ADDR_LOT_LOW, LOT_CODE_DEFAULT[7:0]);
        rd(ADDR_LOT_HIGH, LOT_CODE_DEFAULT[15:8]);
        rd(8'h10, 8'h00);
        host_u.xfer(1'b1, ADDR_TEST_SETTING, 8'hc4);
        rd(ADDR_TEST_SETTING, 8'hc4);
        for (int i = 2; i < 8; i++)
        begin
            host_u.enWr(8'h01 << i);
            rd(ADDR_INT_ENABLE, 8'h01 << i);
        end
        calibrationIrqFlag <= 1'b1;
        rd(ADDR_CALIB_STATUS, 8'h01);
        calibrationIrqFlag <= 1'b0;
        rd(ADDR_CALIB_STATUS, 8'h00);
        pulse();
        rd(ADDR_CALIB_STATUS, 8'h00);
        autoOffsetDecrementEnable <= 1'b1;
        pulse();
        rd(ADDR_CALIB_STATUS, 8'h04);
        outQ.push_back({1'b1, 1'b0, 8'h80});
        host_u.stClr();
        rd(ADDR_CALIB_STATUS, 8'h00);
        pulse();
        autoOffsetDecrementEnable <= 1'b0;
        rd(ADDR_CALIB_STATUS, 8'h00);
        repeat (40)
        begin
            seed = xs(seed);
            {lightSaturationFlag, proxSaturationFlag, proxThresholdFlag} <= seed[2:0];
            {lightColorFlag, calibrationIrqFlag, zeroDetectFlag} <= seed[5:3];
            host_u.enWr(seed[15:8]);
            rd(ADDR_INT_ENABLE, seed[15:8] & MASK_INT_ENABLE);
            outQ.push_back({1'b0, |({seed[2:0], seed[5:3]} & seed[15:10]),
                            seed[15:8] & MASK_INT_ENABLE});
        end
        // let the last notes reach the watching processes
        repeat (2) @(posedge clk_sys);
        if (expQ.size() != 0 || outQ.size() != 0)
            fail_count++;
        test_done();
    end
endmodule : calib_status_irq_enable_regs_tb
